// [rtl/adc_conversion_control.sv]
// Converter control: channel mux, pin takeover, sequencing, flags and APB registers
// Summary of operation
// - Mux one of four channels into one converter; 8-bit successive approximation result.
// - Selected port pin forced to converter input; other pins stay under port control.
// - Port data or direction writes do not affect the selected pin.
// - Reading a selected pin gives 0 if direction is 0, else the data latch.
// - A conversion takes 16 to 17 converter clock cycles.
// - On completion write result to data register and set flag or request interrupt in the same cycle.
// - Continuous mode overwrites the result after every conversion, read or not.
// - Continuous mode runs until software clears the continuous bit or selects the power-down channel.
// - With interrupts disabled the completion flag sets after conversion and a data read clears it; control write loads it from bit 7.
// - Interrupt enabled: request per conversion, CPU if flag 0, DMA if flag 1.
// - With interrupts enabled the flag is not a completion indication.
// - Wait mode keeps converting; a CPU interrupt request wakes the processor, a DMA request does not.
// - Stop mode aborts pending conversion; conversions resume when stop ends.
// - Converter clock is oscillator or bus clock, divided by the divide field.
// - The oscillator clock runs at four times the bus clock.
`timescale 1ns/1ps
`default_nettype none
`include "adc_consts.svh"
module adc_conversion_control import adc_pkg::*; #(
  parameter int WIDTH = 8,
  parameter int PINS = `CH_COUNT
) (
  // Clock (oscillator rate) and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Low-power state of the processor
  input wire logic stop_mode,
  input wire logic wait_mode,
  // Shared port pins
  input wire logic [PINS-1:0] shared_port_pins_in,
  output logic [PINS-1:0] shared_port_pins_out,
  output logic [PINS-1:0] shared_port_pins_oe_n,
  // Analog front end
  input wire logic comp_in,
  output logic [WIDTH-1:0] dac_code,
  output logic [1:0] selected_analog_input,
  output logic analog_enable,
  // Requests
  output logic cpu_irq,
  output logic dma_irq,
  output logic wake_req
);

  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  logic [PINS-1:0] pin_s1_r, pin_s2_r;
  logic comp_s1_r, comp_s2_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      comp_s1_r <= 1'b0;
      comp_s2_r <= 1'b0;
    end else begin
      pin_s1_r <= shared_port_pins_in;
      pin_s2_r <= pin_s1_r;
      comp_s1_r <= comp_in;
      comp_s2_r <= comp_s1_r;
    end
  end

  // ----------------------------------------
  // Registers and state
  // ----------------------------------------
  status_ctrl_t sc_r;
  clk_cfg_t clk_r;
  logic [WIDTH-1:0] data_r;
  logic [PINS-1:0] pdata_r, pdir_r;
  logic pready_r, pslverr_r;
  logic [31:0] prdata_r;
  logic cpu_irq_r, dma_irq_r, wake_r;
  ctl_state_t st_r;
  logic go_r, resume_r;
  logic [1:0] bus_div_r;
  logic [2:0] conv_div_r;
  logic tick_r;
  logic [1:0] asel_r;
  logic aen_r;
  logic [PINS-1:0] pin_out_r, pin_oe_n_r;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire acc = psel & penable;
  // One wait state: the answer comes in the second access cycle
  wire xfer = acc & pready_r;
  wire wr = xfer & pwrite & pstrb[0];
  wire rd = xfer & ~pwrite;
  wire hit_sc = (paddr == `OFS_STATUS_CTRL);
  wire hit_data = (paddr == `OFS_DATA);
  wire hit_clk = (paddr == `OFS_CLK_CFG);
  wire hit_pdata = (paddr == `OFS_PORT_DATA);
  wire hit_pdir = (paddr == `OFS_PORT_DIR);
  wire hit_pin = (paddr == `OFS_PORT_PIN);
  wire mapped = hit_sc | hit_data | hit_clk | hit_pdata | hit_pdir | hit_pin;
  wire wr_sc = wr & hit_sc;
  wire rd_data = rd & hit_data;
  wire [4:0] wch = pwdata[4:0];

  // ----------------------------------------
  // Channel selection and pin takeover
  // ----------------------------------------
  wire power_down = (sc_r.ch == `CH_POWER_DOWN);
  wire ch_valid = (sc_r.ch < 5'(PINS)) & ~power_down;
  logic [PINS-1:0] pin_sel;
  logic [PINS-1:0] pin_read;

  genvar gi;
  generate
    for (gi = 0; gi < PINS; gi++) begin : g_pin
      assign pin_sel[gi] = ch_valid & (sc_r.ch[1:0] == 2'(gi));
      // Selected pin reads the latch only when its direction bit is set
      assign pin_read[gi] = pin_sel[gi] ? (pdir_r[gi] & pdata_r[gi]) :
                            (pdir_r[gi] ? pdata_r[gi] : pin_s2_r[gi]);
    end
  endgenerate

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  logic [31:0] rdata_nxt;
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (hit_sc) begin
      rdata_nxt[7:0] = sc_r;
    end else if (hit_data) begin
      rdata_nxt[WIDTH-1:0] = data_r;
    end else if (hit_clk) begin
      rdata_nxt[7:0] = {clk_r.div, clk_r.osc_sel, 4'h0};
    end else if (hit_pdata) begin
      rdata_nxt[PINS-1:0] = pdata_r;
    end else if (hit_pdir) begin
      rdata_nxt[PINS-1:0] = pdir_r;
    end else if (hit_pin) begin
      rdata_nxt[PINS-1:0] = pin_read;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= acc & ~pready_r;
      pslverr_r <= acc & ~pready_r & ~mapped;
      if (acc & ~pready_r & ~pwrite) begin
        prdata_r <= rdata_nxt;
      end
    end
  end

  // ----------------------------------------
  // Converter clock
  // ----------------------------------------
  // Bus clock is a quarter of the oscillator clock
  wire bus_en = (bus_div_r == 2'(`OSC_PER_BUS - 1));
  wire src_en = clk_r.osc_sel | bus_en;
  // A divide field of zero is taken as divide by one
  wire [2:0] div_last = (clk_r.div == 3'h0) ? 3'h0 : (clk_r.div - 3'h1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_div_r <= 2'h0;
      conv_div_r <= 3'h0;
      tick_r <= 1'b0;
    end else begin
      bus_div_r <= bus_div_r + 2'h1;
      tick_r <= 1'b0;
      if (stop_mode) begin
        conv_div_r <= 3'h0;
      end else if (src_en) begin
        if (conv_div_r >= div_last) begin
          conv_div_r <= 3'h0;
          tick_r <= 1'b1;
        end else begin
          conv_div_r <= conv_div_r + 3'h1;
        end
      end
    end
  end

  // ----------------------------------------
  // Sequencing
  // ----------------------------------------
  logic sar_done;
  logic [WIDTH-1:0] sar_trial;
  wire restart = wr_sc & (wch != `CH_POWER_DOWN);
  wire sar_start = (st_r == CTL_IDLE) & go_r & ~stop_mode & ~power_down & ~wr_sc;
  wire sar_abort = stop_mode | power_down | wr_sc;

  sar_core #(.WIDTH(WIDTH)) u_sar (
    .pclk(pclk),
    .presetn(presetn),
    .start(sar_start),
    .abort(sar_abort),
    .tick(tick_r),
    .comp_hi(comp_s2_r),
    .trial_r(sar_trial),
    .done_r(sar_done),
    .busy()
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= CTL_IDLE;
      go_r <= 1'b0;
      resume_r <= 1'b0;
    end else begin
      case (st_r)
        CTL_IDLE: begin
          if (stop_mode) begin
            st_r <= CTL_STOPPED;
            resume_r <= go_r | restart | sc_r.cont;
          end else if (restart) begin
            go_r <= 1'b1;
          end else if (sar_start) begin
            st_r <= CTL_RUN;
            go_r <= 1'b0;
          end else if (power_down) begin
            go_r <= 1'b0;
          end
        end
        CTL_RUN: begin
          if (stop_mode) begin
            // Conversion in flight is lost
            st_r <= CTL_STOPPED;
            resume_r <= 1'b1;
          end else if (wr_sc) begin
            st_r <= CTL_IDLE;
            go_r <= restart;
          end else if (power_down) begin
            st_r <= CTL_IDLE;
          end else if (sar_done) begin
            st_r <= CTL_IDLE;
            go_r <= sc_r.cont;
          end
        end
        CTL_STOPPED: begin
          if (!stop_mode) begin
            st_r <= CTL_IDLE;
            go_r <= resume_r & ~power_down;
            resume_r <= 1'b0;
          end
        end
        default: st_r <= CTL_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Control, data and completion
  // ----------------------------------------
  wire done_ok = sar_done & (st_r == CTL_RUN) & ~wr_sc;
  // Read clears the flag only while it serves as a completion flag
  wire conv_complete_flag_clr = rd_data & ~sc_r.irq_en;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sc_r <= `SC_RESET;
      clk_r <= `CLK_RESET;
      data_r <= '0;
      pdata_r <= `PORT_RESET;
      pdir_r <= `PORT_RESET;
    end else begin
      if (wr_sc) begin
        sc_r.conv_complete_flag <= pwdata[`SC_CONV_COMPLETE_FLAG_BIT];
        sc_r.irq_en <= pwdata[`SC_IRQEN_BIT];
        sc_r.cont <= pwdata[`SC_CONT_BIT];
        sc_r.ch <= wch;
      end else if (done_ok & ~sc_r.irq_en) begin
        sc_r.conv_complete_flag <= 1'b1;
      end else if (conv_complete_flag_clr) begin
        sc_r.conv_complete_flag <= 1'b0;
      end
      if (done_ok) begin
        data_r <= sar_trial;
      end
      if (wr & hit_clk) begin
        clk_r.div <= pwdata[7:5];
        clk_r.osc_sel <= pwdata[4];
      end
      // Latches still update; the pin driver masks the selected pin
      if (wr & hit_pdata) begin
        pdata_r <= pwdata[PINS-1:0];
      end
      if (wr & hit_pdir) begin
        pdir_r <= pwdata[PINS-1:0];
      end
    end
  end

  // ----------------------------------------
  // Requests
  // ----------------------------------------
  wire irq_set = done_ok & sc_r.irq_en;
  wire irq_clr = wr_sc | rd_data;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_irq_r <= 1'b0;
      dma_irq_r <= 1'b0;
      wake_r <= 1'b0;
    end else begin
      // Set wins over a clear in the same cycle
      if (irq_set & ~sc_r.conv_complete_flag) begin
        cpu_irq_r <= 1'b1;
      end else if (irq_clr) begin
        cpu_irq_r <= 1'b0;
      end
      if (irq_set & sc_r.conv_complete_flag) begin
        dma_irq_r <= 1'b1;
      end else if (irq_clr) begin
        dma_irq_r <= 1'b0;
      end
      wake_r <= wait_mode & cpu_irq_r;
    end
  end

  // ----------------------------------------
  // Pin and analog drivers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out_r <= '0;
      pin_oe_n_r <= '1;
      asel_r <= 2'h0;
      aen_r <= 1'b0;
    end else begin
      pin_out_r <= pdata_r & ~pin_sel;
      pin_oe_n_r <= ~(pdir_r & ~pin_sel);
      asel_r <= sc_r.ch[1:0];
      aen_r <= ch_valid & ~stop_mode;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign shared_port_pins_out = pin_out_r;
  assign shared_port_pins_oe_n = pin_oe_n_r;
  assign dac_code = sar_trial;
  assign selected_analog_input = asel_r;
  assign analog_enable = aen_r;
  assign cpu_irq = cpu_irq_r;
  assign dma_irq = dma_irq_r;
  assign wake_req = wake_r;

endmodule
`default_nettype wire

// [rtl/adc_consts.svh]
// Offsets, field positions, reset values and timing counts of the converter control
`ifndef ADC_CONSTS_SVH
`define ADC_CONSTS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_STATUS_CTRL 8'h3C
`define OFS_DATA 8'h40
`define OFS_CLK_CFG 8'h44
`define OFS_PORT_DATA 8'h48
`define OFS_PORT_DIR 8'h4C
`define OFS_PORT_PIN 8'h50

// ----------------------------------------
// Field positions and codes
// ----------------------------------------
`define SC_CONV_COMPLETE_FLAG_BIT 7
`define SC_IRQEN_BIT 6
`define SC_CONT_BIT 5
`define CH_POWER_DOWN 5'h1F
`define CH_COUNT 4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SC_RESET 8'h1F
`define CLK_RESET 8'h00
`define PORT_RESET 4'h0

// ----------------------------------------
// Timing
// ----------------------------------------
`define CONV_CLKS 16
`define SAMPLE_CLKS 8
`define OSC_PER_BUS 4

`endif

// [rtl/adc_pkg.sv]
// Types shared by the converter control modules
package adc_pkg;

  typedef struct packed {
    logic conv_complete_flag;
    logic irq_en;
    logic cont;
    logic [4:0] ch;
  } status_ctrl_t;

  typedef struct packed {
    logic [2:0] div;
    logic osc_sel;
    logic [3:0] unused;
  } clk_cfg_t;

  typedef enum logic [1:0] {CTL_IDLE, CTL_RUN, CTL_STOPPED} ctl_state_t;

  typedef enum logic [1:0] {SAR_IDLE, SAR_SAMPLE, SAR_TRIAL} sar_state_t;

endpackage

// [rtl/sar_core.sv]
// Successive-approximation sequencer stepped by the conversion clock enable
`timescale 1ns/1ps
`default_nettype none
`include "adc_consts.svh"
module sar_core import adc_pkg::*; #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic start,
  input wire logic abort,
  input wire logic tick,
  // Comparator, synchronised: high when input is at or above the trial level
  input wire logic comp_hi,
  // Results
  output logic [WIDTH-1:0] trial_r,
  output logic done_r,
  output logic busy
);

  sar_state_t state_r;
  logic [3:0] cnt_r;
  logic [WIDTH-1:0] bit_r;

  assign busy = (state_r != SAR_IDLE);

  // Sampling plus one trial per bit makes the conversion length
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= SAR_IDLE;
      cnt_r <= 4'h0;
      bit_r <= '0;
      trial_r <= '0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (abort) begin
        state_r <= SAR_IDLE;
      end else begin
        case (state_r)
          SAR_IDLE: begin
            if (start) begin
              state_r <= SAR_SAMPLE;
              cnt_r <= 4'(`SAMPLE_CLKS - 1);
            end
          end
          SAR_SAMPLE: begin
            if (tick) begin
              cnt_r <= cnt_r - 4'h1;
              if (cnt_r == 4'h0) begin
                state_r <= SAR_TRIAL;
                bit_r <= {1'b1, {(WIDTH-1){1'b0}}};
                trial_r <= {1'b1, {(WIDTH-1){1'b0}}};
              end
            end
          end
          SAR_TRIAL: begin
            if (tick) begin
              // Keep the bit if the input reached the trial level, then try the next
              trial_r <= (comp_hi ? trial_r : (trial_r & ~bit_r)) | (bit_r >> 1);
              bit_r <= bit_r >> 1;
              if (bit_r[0]) begin
                state_r <= SAR_IDLE;
                done_r <= 1'b1;
              end
            end
          end
          default: state_r <= SAR_IDLE;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// [verification/adc_conversion_control_properties.sv]
// Port-level properties of the converter control block
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_control_checker import adc_pkg::*; #(
  parameter int WIDTH = 8,
  parameter int PINS = 4
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus handshake
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Modes and requests
  input wire logic stop_mode,
  input wire logic wait_mode,
  input wire logic cpu_irq,
  input wire logic dma_irq,
  input wire logic wake_req,
  // Pins and mux
  input wire logic [PINS-1:0] shared_port_pins_out,
  input wire logic [PINS-1:0] shared_port_pins_oe_n,
  input wire logic [1:0] selected_analog_input,
  input wire logic analog_enable
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_one_wait;
    psel && penable && !pready |=> pready;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("pready late after access phase");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready held over one cycle");
  property p_err_ready;
    pslverr |-> pready && psel && penable;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("pslverr outside a completing access");
  // Guarded by stable select so a channel change may settle first
  property p_pin_released;
    analog_enable && $past(analog_enable) && $stable(selected_analog_input)
      |-> shared_port_pins_oe_n[selected_analog_input];
  endproperty
  a_pin_released: assert property (p_pin_released) else $error("selected pin still driven");
  property p_pin_low;
    analog_enable && $past(analog_enable) && $stable(selected_analog_input)
      |-> !shared_port_pins_out[selected_analog_input];
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("selected pin output not zero");
  property p_irq_excl;
    !(cpu_irq && dma_irq);
  endproperty
  a_irq_excl: assert property (p_irq_excl) else $error("both request kinds raised");
  property p_wake;
    $rose(wake_req) |-> $past(wait_mode) && $past(cpu_irq);
  endproperty
  a_wake: assert property (p_wake) else $error("wake without waiting request");
  property p_stop_off;
    stop_mode |=> !analog_enable;
  endproperty
  a_stop_off: assert property (p_stop_off) else $error("analog on during stop");
endmodule
bind adc_conversion_control adc_conversion_control_checker #(.WIDTH(WIDTH), .PINS(PINS)) i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .stop_mode(stop_mode), .wait_mode(wait_mode), .cpu_irq(cpu_irq), .dma_irq(dma_irq), .wake_req(wake_req),
  .shared_port_pins_out(shared_port_pins_out), .shared_port_pins_oe_n(shared_port_pins_oe_n),
  .selected_analog_input(selected_analog_input), .analog_enable(analog_enable));
`default_nettype wire

// [verification/analog_source_model.sv]
// Analog sources and pin loads on the far side of the converter
`timescale 1ns/1ps
`default_nettype none
module analog_source_model #(
  parameter int PINS = 4
) (
  // Clock
  input wire logic pclk,
  // From the converter; levels come from the bench
  input wire logic [7:0] dac_code,
  input wire logic [1:0] sel,
  input wire logic analog_enable,
  input wire logic [PINS-1:0] pins_out,
  input wire logic [PINS-1:0] pins_oe_n,
  input wire logic [8*PINS-1:0] levels,
  // To the converter
  output logic comp_in,
  output logic [PINS-1:0] pins_in
);
  logic idle_r = 1'b0;
  always_ff @(posedge pclk) idle_r <= ~idle_r;
  // Mux off: comparator wanders so a stale answer cannot pass
  assign comp_in = analog_enable ? (levels[8*sel +: 8] >= dac_code) : idle_r;
  // Released pins sit on their pull-ups
  assign pins_in = pins_oe_n | pins_out;
endmodule
`default_nettype wire

// [verification/tb_adc_conversion_control.sv]
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
`include "adc_consts.svh"
module tb_adc_conversion_control;
  localparam logic [7:0] sc_a = `OFS_STATUS_CTRL;
  localparam logic [7:0] dat_a = `OFS_DATA;
  localparam logic [7:0] cfg_a = `OFS_CLK_CFG;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic stop_mode = 1'b0, wait_mode = 1'b0;
  logic pready, pslverr, comp_in, analog_enable, cpu_irq, dma_irq, wake_req;
  logic [7:0] paddr = 8'h00, dac_code;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [31:0] levels = 32'hFF5AA500;
  logic [3:0] pins_in, pins_out, pins_oe_n;
  logic [1:0] sel;
  int miscompares = 0;
  int checks = 0;
  always #2 pclk = ~pclk;
  adc_conversion_control i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .stop_mode(stop_mode), .wait_mode(wait_mode), .shared_port_pins_in(pins_in),
    .shared_port_pins_out(pins_out), .shared_port_pins_oe_n(pins_oe_n), .comp_in(comp_in),
    .dac_code(dac_code), .selected_analog_input(sel), .analog_enable(analog_enable),
    .cpu_irq(cpu_irq), .dma_irq(dma_irq), .wake_req(wake_req));
  analog_source_model i_src (.pclk(pclk), .dac_code(dac_code), .sel(sel), .analog_enable(analog_enable),
    .pins_out(pins_out), .pins_oe_n(pins_oe_n), .levels(levels), .comp_in(comp_in), .pins_in(pins_in));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pready", pready, 1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask
  task automatic wait_flag();
    int n;
    n = 0;
    do begin
      rd(sc_a);
      n++;
    end while (q[7] !== 1'b1 && n < 100);
    chk("flag", q[7], 1);
  endtask
  task automatic wait_irq(input logic dma);
    repeat (300) begin
      if ((dma ? dma_irq : cpu_irq) === 1'b1) break;
      @(posedge pclk);
    end
    chk("cpu_irq", cpu_irq, !dma);
    chk("dma_irq", dma_irq, dma);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_reset();
    logic [7:0] a [6] = '{8'h3C, 8'h40, 8'h44, 8'h48, 8'h4C, 8'h00};
    logic e;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, a[i], 32'h0, q, e);
      chk("reset value", q, i == 0 ? `SC_RESET : 0);
      chk("slverr", e, i == 5);
    end
    apb(1'b1, 8'h00, 32'hFF, q, e);
    chk("slverr write", e, 1);
    $display("reset test done");
  endtask
  task automatic test_conv();
    wr(cfg_a, 32'h90);
    for (int ch = 0; ch < 4; ch++) begin
      wr(sc_a, ch);
      repeat (50) @(posedge pclk);
      rd(sc_a);
      chk("early flag", q[7], 0);
      wait_flag();
      chk("mux", sel, ch);
      chk("pin released", pins_oe_n[ch], 1);
      rd(dat_a);
      chk("result", q, levels[8*ch +: 8]);
      rd(sc_a);
      chk("flag cleared", q[7], 0);
    end
    $display("conversion test done");
  endtask
  task automatic test_port();
    wr(sc_a, 1);
    wr(`OFS_PORT_DIR, 32'hF);
    wr(`OFS_PORT_DATA, 32'hF);
    repeat (2) @(posedge pclk);
    chk("pins out", pins_out, 4'hD);
    chk("pins oe", pins_oe_n, 4'h2);
    rd(`OFS_PORT_PIN);
    chk("pin read out", q, 32'hF);
    wr(`OFS_PORT_DIR, 32'h0);
    rd(`OFS_PORT_PIN);
    chk("pin read in", q, 32'hD);
    chk("pins oe off", pins_oe_n, 4'hF);
    $display("port test done");
  endtask
  task automatic test_cont();
    wr(sc_a, 32'h22);
    wait_flag();
    rd(dat_a);
    chk("cont first", q, 32'h5A);
    levels[23:16] <= 8'h33;
    repeat (200) @(posedge pclk);
    rd(dat_a);
    chk("cont overwrite", q, 32'h33);
    wr(sc_a, `SC_RESET);
    rd(dat_a);
    repeat (150) @(posedge pclk);
    rd(sc_a);
    chk("powered down", q, `SC_RESET);
    levels[23:16] <= 8'h5A;
    $display("continuous test done");
  endtask
  task automatic test_irq();
    wr(cfg_a, 32'h20);
    wr(sc_a, 32'h43);
    repeat (50) @(posedge pclk);
    chk("early irq", cpu_irq, 0);
    wait_irq(1'b0);
    wait_mode <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("wake", wake_req, 1);
    wait_mode <= 1'b0;
    rd(dat_a);
    chk("irq result", q, 32'hFF);
    rd(sc_a);
    chk("no flag", q, 32'h43);
    chk("cpu cleared", cpu_irq, 0);
    wr(sc_a, 32'hC3);
    wait_irq(1'b1);
    wr(sc_a, `SC_RESET);
    @(posedge pclk);
    chk("dma cleared", dma_irq, 0);
    wait_mode <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("no wake", wake_req, 0);
    chk("powered off", analog_enable, 0);
    wait_mode <= 1'b0;
    $display("interrupt test done");
  endtask
  task automatic test_stop();
    wr(cfg_a, 32'h90);
    wr(sc_a, 1);
    repeat (20) @(posedge pclk);
    stop_mode <= 1'b1;
    repeat (100) @(posedge pclk);
    chk("analog off", analog_enable, 0);
    rd(sc_a);
    chk("aborted", q, 1);
    stop_mode <= 1'b0;
    wait_flag();
    rd(dat_a);
    chk("resumed", q, 32'hA5);
    $display("stop test done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    test_reset();
    test_conv();
    test_port();
    test_cont();
    test_irq();
    test_stop();
    tally_and_finish();
  end
  // Whole run needs well under this
  initial begin
    repeat (30000) @(posedge pclk);
    miscompares++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
